// ===== include/swire_pkg.sv
// Functional notes
// - Software reset command drives bus reset pulse
// - Busy set while reset, write, read run
// - No presence after reset sets no-slave
// - Line low by other party sets stuck
// - Bus status reads zero when all clear
// - Undriven read bits return one
// - Lengths of one to four bytes, sub-byte
// - Standard or overdrive timing set selectable
// - Normal or late read sample point
// - Presence check after reset can be disabled
// - Normal or inverted bus polarity
// - Single pin or two pin arrangement
// - DMA reset option resets bus first
// - DMA read-after, chained write, chained read
// - Scatter-gather requests on enable and completion
// - DMA transfers 8, 16 or 32 bits
// - Five interrupt sources provided
// - Write-then-read completes only after read
// - Interrupt sources sticky until software clears
// - Only enabled sources reach interrupt line
// - Raw and masked status both readable
// - Write finishes before read begins
// - Bit count programmable one to thirty-two
package swire_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TXN = 4'h1;
  localparam logic [3:0] ADDR_WDATA = 4'h2;
  localparam logic [3:0] ADDR_RDATA = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_RAW = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MSKD = 4'h7;
  localparam logic [3:0] ADDR_DMA = 4'h8;
  localparam logic [3:0] ADDR_TIM_STD = 4'h9;
  localparam logic [3:0] ADDR_TIM_OD = 4'hA;
  // CTRL fields
  localparam int CTRL_OVERDRIVE = 0;
  localparam int CTRL_LATE = 1;
  localparam int CTRL_NO_PRESENCE = 2;
  localparam int CTRL_INVERT = 3;
  localparam int CTRL_TWO_PIN = 4;
  // TXN fields: bit0 reset, bit1 write, bit2 read, [12:8] bit count minus one
  localparam int TXN_RESET = 0;
  localparam int TXN_WRITE = 1;
  localparam int TXN_READ = 2;
  localparam int TXN_CNT_LSB = 8;
  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_NO_SLAVE = 1;
  localparam int ST_STUCK = 2;
  // IRQ fields
  localparam int IRQ_RESET_DONE = 0;
  localparam int IRQ_OP_DONE = 1;
  localparam int IRQ_NO_SLAVE = 2;
  localparam int IRQ_STUCK = 3;
  localparam int IRQ_DMA_DONE = 4;
  localparam int IRQ_W = 5;
  // DMA fields
  localparam int DMA_BUS_RESET = 0;
  localparam int DMA_READ_AFTER = 1;
  localparam int DMA_CHAIN_WRITE = 2;
  localparam int DMA_CHAIN_READ = 3;
  localparam int DMA_SG = 4;
  localparam int DMA_SIZE_LSB = 5;
  localparam logic [1:0] DMA_SIZE_BYTE = 2'h0;
  localparam logic [1:0] DMA_SIZE_HALF = 2'h1;
  localparam logic [1:0] DMA_SIZE_WORD = 2'h2;
  // Timing word: [31:24] reset low/4, [23:16] presence sample, [15:8] slot,
  // [7:4] low for one / sample point, [3:0] late sample extra
  localparam logic [31:0] TIM_STD_RST = 32'h78_12_0E_27;
  localparam logic [31:0] TIM_OD_RST = 32'h0F_03_02_12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'hFFFF_FFFF;
  localparam int STUCK_SLOTS = 4;
  // Read point past release: one cycle plus the two synchroniser stages
  localparam logic [9:0] SAMPLE_LAG = 10'h003;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RST_LOW = 3'b001,
    S_RST_WAIT = 3'b010,
    S_BIT_LOW = 3'b011,
    S_BIT_REST = 3'b100
  } phase_t;
endpackage

// ===== src/swire_pin_sync.sv
`timescale 1ns/1ps
module swire_pin_sync
  import swire_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic coreClk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;
  sync_state_t state_reg, state_next;
  always_comb begin
    state_next.meta = pinIn;
    state_next.sync = state_reg.meta;
  end
  // Bus idles high, so reset to that level to avoid false stuck detection
  always_ff @(posedge coreClk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '1;
    end else begin
      state_reg <= state_next;
    end
  end
  assign pinSync = state_reg.sync;
endmodule

// ===== src/swire_master.sv
`timescale 1ns/1ps
module swire_master
  import swire_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdata,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOeN,
  input wire logic altIn,
  output logic altOut,
  output logic altOeN,
  output logic irq,
  output logic dmaReq,
  input wire logic dmaAck
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] timStd;
    logic [31:0] timOd;
    logic [31:0] wrData;
    logic [31:0] rdData;
    logic [31:0] shiftW;
    logic [31:0] shiftR;
    logic [7:0] dma;
    logic [IRQ_W-1:0] irqRaw;
    logic [IRQ_W-1:0] irqMask;
    logic noSlave;
    logic stuck;
    phase_t phase;
    logic doReset;
    logic doWrite;
    logic doRead;
    logic [4:0] cntLast;
    logic [4:0] bitIdx;
    logic [9:0] timer;
    logic presSeen;
    logic [2:0] stuckCnt;
    logic drvLow;
    logic dmaReq;
    logic [31:0] rdOut;
  } state_t;
  state_t s_reg, s_next;
  logic [1:0] pinSync;
  logic lineHigh;
  logic [31:0] tim;
  logic [9:0] rstLen, presPt, slotLen, lowOne, samplePt;
  logic [4:0] dmaCnt;

  swire_pin_sync #(.WIDTH(2)) u_sync (
    .coreClk(core_clk),
    .rstn(rstn),
    .pinIn({altIn, dataIn}),
    .pinSync(pinSync)
  );

  // Two pin arrangement senses on the alternate pin polarity applied
  assign lineHigh = (s_reg.ctrl[CTRL_TWO_PIN] ? pinSync[1] : pinSync[0])
                    ^ s_reg.ctrl[CTRL_INVERT];
  // Timing set per speed, all from programmable counts
  assign tim = s_reg.ctrl[CTRL_OVERDRIVE] ? s_reg.timOd : s_reg.timStd;
  assign rstLen = {tim[31:24], 2'b00};
  assign presPt = {2'b00, tim[23:16]};
  assign slotLen = {2'b00, tim[15:8]};
  assign lowOne = {6'h00, tim[7:4]};
  // Late sampling moves the read point later in the slot
  assign samplePt = s_reg.ctrl[CTRL_LATE] ? lowOne + {6'h00, tim[3:0]} + SAMPLE_LAG
                                          : lowOne + SAMPLE_LAG;
  always_comb begin
    unique case (s_reg.dma[DMA_SIZE_LSB +: 2])
      DMA_SIZE_HALF: dmaCnt = 5'h0F;
      DMA_SIZE_WORD: dmaCnt = 5'h1F;
      default: dmaCnt = 5'h07;
    endcase
  end

  always_comb begin
    logic [IRQ_W-1:0] irqSet;
    logic startTxn;
    logic opDone;
    logic rdBit;
    irqSet = '0;
    startTxn = 1'b0;
    opDone = 1'b0;
    rdBit = 1'b1;
    s_next = s_reg;
    s_next.timer = s_reg.timer + 10'h001;
    s_next.dmaReq = 1'b0;
    s_next.rdOut = 32'h0000_0000;

    if (rdStb) begin
      unique case (addr)
        ADDR_CTRL: s_next.rdOut = s_reg.ctrl;
        ADDR_WDATA: s_next.rdOut = s_reg.wrData;
        ADDR_RDATA: s_next.rdOut = s_reg.rdData;
        ADDR_STATUS: s_next.rdOut = {29'h0, s_reg.stuck, s_reg.noSlave,
                                     s_reg.phase != S_IDLE};
        ADDR_IRQ_RAW: s_next.rdOut = {27'h0, s_reg.irqRaw};
        ADDR_IRQ_MASK: s_next.rdOut = {27'h0, s_reg.irqMask};
        ADDR_IRQ_MSKD: s_next.rdOut = {27'h0, s_reg.irqRaw & s_reg.irqMask};
        ADDR_DMA: s_next.rdOut = {24'h0, s_reg.dma};
        ADDR_TIM_STD: s_next.rdOut = s_reg.timStd;
        ADDR_TIM_OD: s_next.rdOut = s_reg.timOd;
        default: s_next.rdOut = 32'h0000_0000;
      endcase
    end

    if (wrStb) begin
      unique case (addr)
        ADDR_CTRL: s_next.ctrl = wdata;
        ADDR_WDATA: s_next.wrData = wdata;
        ADDR_IRQ_RAW: s_next.irqRaw = s_reg.irqRaw & ~wdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: s_next.irqMask = wdata[IRQ_W-1:0];
        ADDR_DMA: begin
          s_next.dma = wdata[7:0];
          // Scatter-gather asks for service at once on enable
          s_next.dmaReq = wdata[DMA_SG];
          if (wdata[DMA_BUS_RESET] && s_reg.phase == S_IDLE) begin
            s_next.doReset = 1'b1;
            // Reset alone; a previous command's transfer flags must not follow it
            s_next.doWrite = 1'b0;
            s_next.doRead = 1'b0;
            startTxn = 1'b1;
          end
        end
        ADDR_TIM_STD: s_next.timStd = wdata;
        ADDR_TIM_OD: s_next.timOd = wdata;
        ADDR_TXN: begin
          // Starts only when idle; a write while busy is dropped
          if (s_reg.phase == S_IDLE) begin
            s_next.doReset = wdata[TXN_RESET];
            s_next.doWrite = wdata[TXN_WRITE];
            s_next.doRead = wdata[TXN_READ];
            s_next.cntLast = wdata[TXN_CNT_LSB +: 5];
            startTxn = |wdata[TXN_READ:TXN_RESET];
          end
        end
        default: ;
      endcase
    end

    // DMA acknowledge launches a sized transfer when the bus is idle
    if (dmaAck && s_reg.phase == S_IDLE && !startTxn) begin
      s_next.cntLast = dmaCnt;
      s_next.doReset = 1'b0;
      s_next.doWrite = s_reg.dma[DMA_CHAIN_WRITE];
      s_next.doRead = s_reg.dma[DMA_CHAIN_READ] | s_reg.dma[DMA_READ_AFTER];
      if (wrStb && addr == ADDR_WDATA) begin
        s_next.shiftW = wdata;
      end
      startTxn = 1'b1;
    end

    unique case (s_reg.phase)
      S_IDLE: begin
        if (startTxn) begin
          s_next.timer = '0;
          s_next.bitIdx = '0;
          s_next.shiftW = (wrStb && addr == ADDR_WDATA) ? wdata : s_reg.wrData;
          s_next.shiftR = RDATA_RST;
          if (s_next.doReset) begin
            s_next.phase = S_RST_LOW;
            s_next.drvLow = 1'b1;
            s_next.presSeen = 1'b0;
          end else begin
            s_next.phase = S_BIT_LOW;
            s_next.drvLow = 1'b1;
          end
        end
      end
      S_RST_LOW: begin
        // Timer starts at zero, so leave one early to hold exactly rstLen cycles
        if (s_reg.timer >= rstLen - 10'h001) begin
          s_next.phase = S_RST_WAIT;
          s_next.drvLow = 1'b0;
          s_next.timer = '0;
        end
      end
      S_RST_WAIT: begin
        if (s_reg.timer == presPt && !lineHigh) begin
          s_next.presSeen = 1'b1;
        end
        if (s_reg.timer >= rstLen) begin
          s_next.doReset = 1'b0;
          s_next.timer = '0;
          irqSet[IRQ_RESET_DONE] = 1'b1;
          if (!s_reg.presSeen && !s_reg.ctrl[CTRL_NO_PRESENCE]) begin
            s_next.noSlave = 1'b1;
            irqSet[IRQ_NO_SLAVE] = 1'b1;
          end else begin
            s_next.noSlave = 1'b0;
          end
          if (s_reg.doWrite || s_reg.doRead) begin
            s_next.phase = S_BIT_LOW;
            s_next.drvLow = 1'b1;
          end else begin
            s_next.phase = S_IDLE;
          end
        end
      end
      S_BIT_LOW: begin
        // A write of 1 and any read release early; a write of 0 holds the slot
        if (s_reg.timer >= lowOne && !(s_reg.doWrite && !s_reg.shiftW[0])) begin
          s_next.drvLow = 1'b0;
          s_next.phase = S_BIT_REST;
        end
        if (s_reg.timer >= slotLen - 10'h002) begin
          s_next.drvLow = 1'b0;
          s_next.phase = S_BIT_REST;
        end
      end
      S_BIT_REST: begin
        if (!s_reg.doWrite && s_reg.timer == samplePt) begin
          rdBit = lineHigh;
          // Assemble LSB first: shift right, new bit enters at bit 31
          s_next.shiftR = {rdBit, s_reg.shiftR[31:1]};
        end
        if (s_reg.timer >= slotLen) begin
          s_next.timer = '0;
          if (s_reg.bitIdx == s_reg.cntLast) begin
            s_next.bitIdx = '0;
            if (s_reg.doWrite && s_reg.doRead) begin
              s_next.doWrite = 1'b0;
              s_next.shiftR = RDATA_RST;
              s_next.phase = S_BIT_LOW;
              s_next.drvLow = 1'b1;
            end else begin
              s_next.phase = S_IDLE;
              opDone = 1'b1;
              if (!s_reg.doWrite) begin
                // Right-align; bits above the count read as one
                s_next.rdData = ~(~s_reg.shiftR >> (5'd31 - s_reg.cntLast));
              end
            end
          end else begin
            s_next.bitIdx = s_reg.bitIdx + 5'h01;
            s_next.shiftW = {1'b1, s_reg.shiftW[31:1]};
            s_next.phase = S_BIT_LOW;
            s_next.drvLow = 1'b1;
          end
        end
      end
      default: s_next.phase = S_IDLE;
    endcase

    // Line low while released with the bus idle (S_IDLE) counts as stuck
    if (!s_reg.drvLow && !lineHigh && s_reg.phase == S_IDLE) begin
      if (s_reg.timer[7:0] == 8'hFF) begin
        if (s_reg.stuckCnt != 3'(STUCK_SLOTS)) begin
          s_next.stuckCnt = s_reg.stuckCnt + 3'h1;
        end else begin
          s_next.stuck = 1'b1;
          irqSet[IRQ_STUCK] = !s_reg.stuck;
        end
      end
    end else if (lineHigh) begin
      s_next.stuckCnt = '0;
      s_next.stuck = 1'b0;
    end

    if (opDone) begin
      irqSet[IRQ_OP_DONE] = 1'b1;
      if (s_reg.dma[DMA_CHAIN_WRITE] | s_reg.dma[DMA_CHAIN_READ] | s_reg.dma[DMA_SG]
          | s_reg.dma[DMA_READ_AFTER]) begin
        s_next.dmaReq = 1'b1;
        irqSet[IRQ_DMA_DONE] = 1'b1;
      end
    end
    // Set wins over a clear in the same cycle
    s_next.irqRaw = s_next.irqRaw | irqSet;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.timStd <= TIM_STD_RST;
      s_reg.timOd <= TIM_OD_RST;
      s_reg.rdData <= RDATA_RST;
      s_reg.phase <= S_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Open drain: enable low drives the level that means line low
  assign dataOut = s_reg.ctrl[CTRL_INVERT];
  assign altOut = s_reg.ctrl[CTRL_INVERT];
  assign dataOeN = !s_reg.drvLow;
  assign altOeN = !(s_reg.drvLow && s_reg.ctrl[CTRL_TWO_PIN]);
  assign irq = |(s_reg.irqRaw & s_reg.irqMask);
  assign dmaReq = s_reg.dmaReq;
  assign rdata = s_reg.rdOut;

  property p_busy_reset;
    @(posedge core_clk) disable iff (!rstn)
      (wrStb && addr == ADDR_TXN && wdata[TXN_RESET] && s_reg.phase == S_IDLE)
      |=> s_reg.phase == S_RST_LOW && s_reg.drvLow;
  endproperty
  a_busy_reset: assert property (p_busy_reset) else $error("reset not started");

  property p_irq_mask;
    @(posedge core_clk) disable iff (!rstn)
      irq == |(s_reg.irqRaw & s_reg.irqMask);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq mask wrong");

  property p_sticky;
    @(posedge core_clk) disable iff (!rstn)
      (s_reg.irqRaw[IRQ_OP_DONE] && !(wrStb && addr == ADDR_IRQ_RAW))
      |=> s_reg.irqRaw[IRQ_OP_DONE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped");

  property p_rdata_lat;
    @(posedge core_clk) disable iff (!rstn)
      (rdStb && addr == ADDR_IRQ_MASK) |=> rdata == {27'h0, $past(s_reg.irqMask)};
  endproperty
  a_rdata_lat: assert property (p_rdata_lat) else $error("read data late");

  property p_status_busy;
    @(posedge core_clk) disable iff (!rstn)
      (rdStb && addr == ADDR_STATUS) |=> rdata[ST_BUSY] == ($past(s_reg.phase) != S_IDLE);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy flag wrong");

  property p_no_slave;
    @(posedge core_clk) disable iff (!rstn)
      (s_reg.phase == S_RST_WAIT && s_reg.timer >= rstLen && !s_reg.presSeen
       && !s_reg.ctrl[CTRL_NO_PRESENCE]) |=> s_reg.noSlave && s_reg.irqRaw[IRQ_NO_SLAVE];
  endproperty
  a_no_slave: assert property (p_no_slave) else $error("no slave not flagged");

  property p_alt_quiet;
    @(posedge core_clk) disable iff (!rstn)
      !s_reg.ctrl[CTRL_TWO_PIN] |-> altOeN;
  endproperty
  a_alt_quiet: assert property (p_alt_quiet) else $error("alt pin driven");

  property p_wr_then_rd;
    @(posedge core_clk) disable iff (!rstn)
      (s_reg.phase == S_BIT_REST && s_reg.timer >= slotLen && s_reg.bitIdx == s_reg.cntLast
       && s_reg.doWrite && s_reg.doRead) |=> s_reg.phase == S_BIT_LOW && !s_reg.doWrite;
  endproperty
  a_wr_then_rd: assert property (p_wr_then_rd) else $error("read not after write");
endmodule

// ===== tb/swire_slave_model.sv
`timescale 1ns/1ps
module swire_slave_model (
  input wire logic clk,
  input wire logic line,
  input wire logic present,
  input wire logic stuck,
  input wire logic [31:0] pattern,
  output logic pullLow
);
  int lowCnt = 0;
  int hold = 0;
  int idx = 0;
  logic prevLine = 1'b1;
  // A bit left alone floats to the pull-up and reads as one
  assign pullLow = stuck | (hold > 0);
  always @(posedge clk) begin
    prevLine <= line;
    if (hold > 0) hold <= hold - 1;
    if (!line) lowCnt <= lowCnt + 1;
    else lowCnt <= 0;
    if (line && lowCnt > 40) begin
      idx <= 0;
      // Long pulse covers the sample point at either speed
      if (present) hold <= 40;
    end else if (prevLine && !line && hold == 0) begin
      if (!pattern[idx[4:0]]) hold <= 10;
      idx <= idx + 1;
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import swire_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic dmaAck = 1'b0;
  logic present = 1'b1;
  logic stuck = 1'b0;
  logic altSeen = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] pattern = 32'hFFFF_FFFF;
  logic [31:0] rdata, r;
  logic dataOut, dataOeN, altOut, altOeN, irq, dmaReq, slavePull, line;
  int num_errors = 0;
  int total_checks = 0;
  int lowCnt = 0;
  int nRst = 0;
  int rstLen = 0;
  int nReq = 0;
  logic bits[$];
  int lens[5] = '{8, 1, 32, 13, 32};
  logic [31:0] pats[5] = '{32'h5A, 32'h0, 32'h1234_ABCD, 32'h1A5C, 32'hFFFF_FFFF};
  assign line = (dataOeN | dataOut) & (altOeN | altOut) & ~slavePull;
  swire_master uut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .dataIn(line), .dataOut(dataOut),
    .dataOeN(dataOeN), .altIn(line), .altOut(altOut), .altOeN(altOeN), .irq(irq),
    .dmaReq(dmaReq), .dmaAck(dmaAck));
  swire_slave_model slave (.clk(core_clk), .line(line), .present(present), .stuck(stuck),
    .pattern(pattern), .pullLow(slavePull));
  initial forever #25 core_clk = ~core_clk;
  // Pulse widths are taken from the master's own enable, so slave pulls do not blur them
  always @(posedge core_clk) begin
    if (dmaReq === 1'b1) nReq++;
    if (altOeN === 1'b0) altSeen = 1'b1;
    if (dataOeN === 1'b0) lowCnt++;
    else if (lowCnt > 0) begin
      if (lowCnt > 40) begin
        nRst++;
        rstLen = lowCnt;
      end else bits.push_back(lowCnt < 7);
      lowCnt = 0;
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge core_clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Polls busy; optionally checks that completion is not flagged early
  task automatic idle(input bit watchOp);
    int n = 0;
    logic [31:0] s;
    rd(ADDR_STATUS, s);
    while (s[ST_BUSY] !== 1'b0) begin
      if (watchOp) rd(ADDR_IRQ_RAW, r);
      if (++n > 3000) begin
        chk(0, 1, "busy timeout");
        test_done;
      end
      rd(ADDR_STATUS, s);
      // A raw read taken before a busy status read must not show completion
      if (watchOp && s[ST_BUSY]) chk(r[IRQ_OP_DONE], 0, "early done");
    end
  endtask
  task automatic txn(input logic [31:0] t, input logic [31:0] d, input bit watchOp);
    wr(ADDR_IRQ_RAW, 32'h1F);
    wr(ADDR_WDATA, d);
    bits.delete();
    nRst = 0;
    wr(ADDR_TXN, t);
    idle(watchOp);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    chk(0, 1, "run timeout");
    test_done;
  end
  initial begin
    int n;
    logic [63:0] m;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rd(ADDR_CTRL, r);
    chk(r, CTRL_RST, "ctrl rst");
    rd(ADDR_RDATA, r);
    chk(r, 32'hFFFF_FFFF, "rdata rst");
    rd(ADDR_STATUS, r);
    chk(r, 32'h0, "status rst");
    rd(ADDR_TIM_STD, r);
    chk(r, TIM_STD_RST, "tim std");
    rd(ADDR_TIM_OD, r);
    chk(r, TIM_OD_RST, "tim od");
    rd(4'hF, r);
    chk(r, 32'h0, "unmapped");
    $display("test registers done");
    bits.delete();
    nRst = 0;
    wr(ADDR_TXN, 32'h1);
    rd(ADDR_STATUS, r);
    chk(r[ST_BUSY], 1, "busy");
    wr(ADDR_TXN, 32'h0704);
    idle(0);
    chk(nRst, 1, "reset pulse");
    chk(rstLen, 4 * TIM_STD_RST[31:24], "reset len");
    chk(bits.size(), 0, "busy txn refused");
    rd(ADDR_STATUS, r);
    chk(r, 32'h0, "status idle");
    rd(ADDR_IRQ_RAW, r);
    chk(r, 32'h1 << IRQ_RESET_DONE, "reset irq");
    present <= 1'b0;
    txn(32'h1, 0, 0);
    rd(ADDR_STATUS, r);
    chk(r[ST_NO_SLAVE], 1, "no slave");
    rd(ADDR_IRQ_RAW, r);
    chk(r[IRQ_NO_SLAVE], 1, "no slave irq");
    wr(ADDR_CTRL, 32'h1 << CTRL_NO_PRESENCE);
    txn(32'h1, 0, 0);
    rd(ADDR_IRQ_RAW, r);
    chk(r, 32'h1 << IRQ_RESET_DONE, "presence off");
    chk(irq, 0, "masked off");
    wr(ADDR_IRQ_MASK, 32'h1 << IRQ_RESET_DONE);
    rd(ADDR_IRQ_MSKD, r);
    chk(r, 32'h1 << IRQ_RESET_DONE, "masked view");
    chk(irq, 1, "irq on");
    rd(ADDR_IRQ_RAW, r);
    chk(r[IRQ_RESET_DONE], 1, "sticky");
    wr(ADDR_IRQ_RAW, 32'h1 << IRQ_RESET_DONE);
    @(posedge core_clk);
    chk(irq, 0, "cleared");
    wr(ADDR_CTRL, 32'h0);
    present <= 1'b1;
    $display("test reset and irq done");
    for (int i = 0; i < 5; i++) begin
      n = lens[i];
      pattern <= pats[i];
      txn(32'h5 | ((n - 1) << TXN_CNT_LSB), 0, 0);
      m = (64'h1 << n) - 1;
      rd(ADDR_RDATA, r);
      chk(r, pats[i] | ~m[31:0], "read data");
    end
    pattern <= 32'h5A;
    wr(ADDR_CTRL, 32'h1 << CTRL_LATE);
    txn(32'h5 | (7 << TXN_CNT_LSB), 0, 0);
    rd(ADDR_RDATA, r);
    chk(r, 32'hFFFF_FF5A, "late read");
    wr(ADDR_CTRL, 32'h0);
    pattern <= 32'hFFFF_FFFF;
    txn(32'h3 | (11 << TXN_CNT_LSB), 32'hA5C, 0);
    chk(bits.size(), 12, "write slots");
    foreach (bits[i]) chk(bits[i], 32'hA5C >> i & 1, "write bit");
    pattern <= 32'h9F;
    txn(32'h7 | (3 << TXN_CNT_LSB), 32'h6, 1);
    rd(ADDR_IRQ_RAW, r);
    chk(r[IRQ_OP_DONE], 1, "op done");
    chk(bits.size(), 8, "wr rd slots");
    for (int i = 0; i < 4; i++) chk(bits[i], 32'h6 >> i & 1, "wr first");
    rd(ADDR_RDATA, r);
    chk(r, 32'hFFFF_FFF9, "rd after wr");
    $display("test transfers done");
    wr(ADDR_CTRL, (32'h1 << CTRL_OVERDRIVE) | (32'h1 << CTRL_NO_PRESENCE));
    txn(32'h1, 0, 0);
    chk(rstLen, 4 * TIM_OD_RST[31:24], "od reset");
    wr(ADDR_CTRL, 32'h1 << CTRL_TWO_PIN);
    wr(ADDR_TIM_STD, 32'h1012_0E27);
    chk(altSeen, 0, "alt idle");
    txn(32'h1, 0, 0);
    chk(rstLen, 64, "tim prog");
    chk(altSeen, 1, "alt pin");
    wr(ADDR_TIM_STD, TIM_STD_RST);
    wr(ADDR_CTRL, 32'h1 << CTRL_INVERT);
    #1;
    chk(dataOut, 1, "invert");
    chk(altOut, 1, "alt invert");
    wr(ADDR_CTRL, 32'h0);
    #1;
    chk(dataOut, 0, "normal");
    chk(altOut, 0, "alt normal");
    $display("test config done");
    nReq = 0;
    wr(ADDR_DMA, 32'h1 << DMA_SG);
    repeat (10) @(posedge core_clk);
    chk(nReq != 0, 1, "sg request");
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_IRQ_RAW, 32'h1F);
      bits.delete();
      nRst = 0;
      // Enabling with the reset option starts the bus reset at once
      wr(ADDR_DMA, 32'h3 | (s << DMA_SIZE_LSB));
      idle(0);
      nReq = 0;
      @(posedge core_clk);
      dmaAck <= 1'b1;
      @(posedge core_clk);
      dmaAck <= 1'b0;
      idle(0);
      chk(nRst, 1, "dma reset");
      chk(bits.size(), 8 << s, "dma size");
      chk(nReq, 1, "dma next request");
      rd(ADDR_IRQ_RAW, r);
      chk(r[IRQ_DMA_DONE], 1, "dma done irq");
    end
    wr(ADDR_DMA, 32'h0);
    $display("test dma done");
    stuck <= 1'b1;
    n = 0;
    r = 0;
    while (r[ST_STUCK] !== 1'b1 && n < 2000) begin
      rd(ADDR_STATUS, r);
      n++;
    end
    chk(r[ST_STUCK], 1, "stuck");
    rd(ADDR_IRQ_RAW, r);
    chk(r[IRQ_STUCK], 1, "stuck irq");
    stuck <= 1'b0;
    $display("test stuck done");
    test_done;
  end
endmodule
